// [shared/dsp_pkg.sv]
// constants, register map and carrier types for the eight-pin digital/servo port
package dsp_pkg;
  localparam int unsigned NPIN      = 8;
  localparam int unsigned NSRV      = 4;
  localparam int unsigned SRV_OBASE = 4;
  localparam int unsigned CFG_W     = 3;

  // timing, in milliseconds and in cycles of the 40 MHz core clock
  localparam int unsigned CLK_HZ    = 40_000_000;
  localparam int unsigned FRAME_MS  = 20;
  localparam int unsigned PMIN_MS   = 1;
  localparam int unsigned PMAX_MS   = 2;
  localparam int unsigned FRAME_CYC = (CLK_HZ / 1000) * FRAME_MS;
  localparam int unsigned PMIN_CYC  = (CLK_HZ / 1000) * PMIN_MS;
  localparam int unsigned PMAX_CYC  = (CLK_HZ / 1000) * PMAX_MS;
  localparam int unsigned POS_MAX   = 255;

  // pin function codes
  localparam logic [2:0] MODE_IN      = 3'h0;
  localparam logic [2:0] MODE_OUT     = 3'h1;
  localparam logic [2:0] MODE_SRV_IN  = 3'h2;
  localparam logic [2:0] MODE_SRV_OUT = 3'h3;
  localparam logic [2:0] MODE_SIG_OUT = 3'h6;
  localparam logic [2:0] MODE_SIG_IN  = 3'h7;

  // register byte offsets
  localparam logic [7:0] ADDR_CFG     = 8'h00;
  localparam logic [7:0] ADDR_STATE   = 8'h04;
  localparam logic [7:0] ADDR_SRV_EN  = 8'h08;
  localparam logic [7:0] ADDR_POS_OUT = 8'h0c;
  localparam logic [7:0] ADDR_POS_IN  = 8'h10;

  // reset values
  localparam logic [23:0] CFG_RST   = 24'h000000;
  localparam logic [7:0]  LEVEL_RST = 8'h00;
  localparam logic [7:0]  EN_RST    = 8'h00;
  localparam logic [7:0]  POS_RST   = 8'h00;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } dsp_bus_t;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
    logic [7:0] pd;
  } dsp_pin_drv_t;

  typedef struct packed {
    logic [NPIN-1:0][CFG_W-1:0] cfg;
    logic [NPIN-1:0]            level;
    logic [NPIN-1:0]            srv_en;
    logic [NSRV-1:0][7:0]       pos_out;
    logic [NSRV-1:0][7:0]       hold;
    logic [NSRV-1:0][7:0]       pos_in;
    logic [NSRV-1:0][20:0]      meas;
    logic [19:0]                frame;
    logic [NPIN-1:0]            s1;
    logic [NPIN-1:0]            s2;
    logic [NPIN-1:0]            s3;
    dsp_pin_drv_t               drv;
    logic [31:0]                rdata;
  } dsp_state_t;
endpackage

// [design/dsp_top.sv]
// eight digital pins with plain, servo-measure and servo-generate functions
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps

// Behaviour
// RULE1 - eight pins, each an input or an output by its configuration
// RULE2 - code selects function: 0 in, 1 out, 2/3 servo, 6/7 waveform; here code 6 only drives the pin low, 7 is a plain input
// RULE3 - plain output drives the last level written to its state bit
// RULE4 - plain input reads back the level sampled on the pin
// RULE5 - any input configuration turns on the weak pull-down
// RULE6 - servo measuring only on pins 0-3, generating only on pins 4-7
// RULE7 - software sets servo mode before enabling; otherwise enable does nothing
// RULE8 - enabled servo output repeats a 20 ms frame, high 1 to 2 ms
// RULE9 - enabled servo input measures high time and reports position
// RULE10 - position maps linearly, 0 gives 1 ms, 255 gives 2 ms; disabled low
module dsp_top #(
  parameter int unsigned FRAME_CYC = dsp_pkg::FRAME_CYC,
  parameter int unsigned PMIN_CYC  = dsp_pkg::PMIN_CYC,
  parameter int unsigned PMAX_CYC  = dsp_pkg::PMAX_CYC
) (
  input  wire logic                  core_clk_in,
  input  wire logic                  resetn_in,
  input  wire dsp_pkg::dsp_bus_t     bus_in,
  output logic [31:0]                bus_rdata_out,
  input  wire logic [7:0]            pin_in,
  output dsp_pkg::dsp_pin_drv_t      pin_drv_out
);
  localparam int unsigned SPAN = PMAX_CYC - PMIN_CYC;

  logic [1:0]          rst_s_q;
  logic                rst_n;
  dsp_pkg::dsp_state_t st_q;
  dsp_pkg::dsp_state_t st_d;

  // reset enters asynchronously but is released on the clock
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_s_q <= 2'h0;
    end else begin
      rst_s_q <= {rst_s_q[0], 1'b1};
    end
  end
  assign rst_n = rst_s_q[1];

  function automatic logic [20:0] pos2cyc(input logic [7:0] p);
    logic [31:0] t;
    t = (32'(p) * SPAN) / dsp_pkg::POS_MAX;
    return 21'(PMIN_CYC + t);
  endfunction

  // out-of-range pulses clamp to the end positions
  function automatic logic [7:0] cyc2pos(input logic [20:0] m);
    logic [31:0] t;
    t = 32'h0;
    if (32'(m) <= PMIN_CYC) begin
      return 8'h00;
    end
    if (32'(m) >= PMAX_CYC) begin
      return 8'hff;
    end
    t = ((32'(m) - PMIN_CYC) * dsp_pkg::POS_MAX) / SPAN;
    return t[7:0];
  endfunction

  function automatic logic is_input(input logic [2:0] m);
    return !(m == dsp_pkg::MODE_OUT || m == dsp_pkg::MODE_SRV_OUT ||
             m == dsp_pkg::MODE_SIG_OUT);
  endfunction

  always_comb begin
    logic [2:0] m;
    logic       srv_on;
    m      = 3'h0;
    srv_on = 1'b0;
    st_d   = st_q;
    st_d.rdata = 32'h0;
    // pin synchroniser: s1 feeds only s2, s3 holds the last s2 for edges
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;

    // shared frame timer; all servo outputs start their frames together
    if (st_q.frame == 20'(FRAME_CYC - 1)) begin
      st_d.frame = 20'h0;
    end else begin
      st_d.frame = st_q.frame + 20'h1;
    end

    if (bus_in.wr) begin
      case (bus_in.addr)
        dsp_pkg::ADDR_CFG:     st_d.cfg     = bus_in.wdata[23:0];
        dsp_pkg::ADDR_STATE:   st_d.level   = bus_in.wdata[7:0]; // [RULE3]
        dsp_pkg::ADDR_SRV_EN:  st_d.srv_en  = bus_in.wdata[7:0];
        dsp_pkg::ADDR_POS_OUT: st_d.pos_out = bus_in.wdata;
        default: ;
      endcase
    end

    for (int i = 0; i < dsp_pkg::NPIN; i++) begin
      m = st_q.cfg[i];
      // undefined codes are treated as inputs so the pin never fights
      st_d.drv.oe[i] = !is_input(m); // [RULE1] [RULE2]
      st_d.drv.pd[i] = is_input(m);  // [RULE5]
      case (m)
        dsp_pkg::MODE_OUT:     st_d.drv.o[i] = st_q.level[i]; // [RULE3]
        dsp_pkg::MODE_SRV_OUT: st_d.drv.o[i] = 1'b0;
        default:               st_d.drv.o[i] = 1'b0;
      endcase
    end

    // generators live on pins 4-7 only
    for (int j = 0; j < dsp_pkg::NSRV; j++) begin
      srv_on = st_q.srv_en[dsp_pkg::SRV_OBASE + j] &&
               st_q.cfg[dsp_pkg::SRV_OBASE + j] == dsp_pkg::MODE_SRV_OUT; // [RULE6] [RULE7]
      // position is sampled once per frame so a write never cuts a pulse short
      if (st_q.frame == 20'h0) begin
        st_d.hold[j] = st_q.pos_out[j];
      end
      if (srv_on) begin
        st_d.drv.o[dsp_pkg::SRV_OBASE + j] =
          {1'b0, st_q.frame} < pos2cyc(st_q.hold[j]); // [RULE8] [RULE10]
      end
    end

    // measurers live on pins 0-3 only
    for (int j = 0; j < dsp_pkg::NSRV; j++) begin
      srv_on = st_q.srv_en[j] && st_q.cfg[j] == dsp_pkg::MODE_SRV_IN; // [RULE6] [RULE7]
      if (st_q.s2[j] && !st_q.s3[j]) begin
        st_d.meas[j] = 21'h1;
      end else if (st_q.s2[j] && st_q.meas[j] != 21'h1fffff) begin
        st_d.meas[j] = st_q.meas[j] + 21'h1;
      end
      if (srv_on && !st_q.s2[j] && st_q.s3[j]) begin
        st_d.pos_in[j] = cyc2pos(st_q.meas[j]); // [RULE9] [RULE10]
      end
    end

    if (bus_in.rd) begin
      case (bus_in.addr)
        dsp_pkg::ADDR_CFG:     st_d.rdata = {8'h0, st_q.cfg};
        dsp_pkg::ADDR_STATE: begin
          for (int i = 0; i < dsp_pkg::NPIN; i++) begin
            st_d.rdata[i] = is_input(st_q.cfg[i]) ? st_q.s2[i] : st_q.drv.o[i]; // [RULE4]
          end
        end
        dsp_pkg::ADDR_SRV_EN:  st_d.rdata = {24'h0, st_q.srv_en};
        dsp_pkg::ADDR_POS_OUT: st_d.rdata = st_q.pos_out;
        dsp_pkg::ADDR_POS_IN:  st_d.rdata = st_q.pos_in;
        default:               st_d.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      st_q         <= '0;
      st_q.cfg     <= dsp_pkg::CFG_RST;
      st_q.level   <= dsp_pkg::LEVEL_RST;
      st_q.srv_en  <= dsp_pkg::EN_RST;
      st_q.pos_out <= {4{dsp_pkg::POS_RST}};
      st_q.drv.pd  <= 8'hff;
    end else begin
      st_q <= st_d;
    end
  end

  assign bus_rdata_out = st_q.rdata;
  assign pin_drv_out   = st_q.drv;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n);

  sequence srv4_on_s;
    st_q.srv_en[4] && st_q.cfg[4] == dsp_pkg::MODE_SRV_OUT;
  endsequence

  sequence srv5_on_s;
    st_q.srv_en[5] && st_q.cfg[5] == dsp_pkg::MODE_SRV_OUT;
  endsequence

  pin_direction_a: assert property ( // [RULE1]
    ##1 (pin_drv_out.oe ^ pin_drv_out.pd) == 8'hff)
    else $error("pin neither input nor output");

  mode_decode_a: assert property ( // [RULE2]
    st_q.cfg[1] == dsp_pkg::MODE_SIG_OUT |=> pin_drv_out.oe[1] && !pin_drv_out.pd[1])
    else $error("waveform output code not decoded as output");

  drive_level_a: assert property ( // [RULE3]
    st_q.cfg[2] == dsp_pkg::MODE_OUT |=> pin_drv_out.o[2] == $past(st_q.level[2]))
    else $error("plain output level wrong");

  read_input_a: assert property ( // [RULE4]
    bus_in.rd && bus_in.addr == dsp_pkg::ADDR_STATE && st_q.cfg[0] == dsp_pkg::MODE_IN
    |=> bus_rdata_out[0] == $past(st_q.s2[0]))
    else $error("input read-back wrong");

  pull_down_a: assert property ( // [RULE5]
    st_q.cfg[3] == dsp_pkg::MODE_SRV_IN || st_q.cfg[3] == dsp_pkg::MODE_SIG_IN
    |=> pin_drv_out.pd[3] && !pin_drv_out.oe[3])
    else $error("input pin without pull-down");

  servo_side_a: assert property ( // [RULE6]
    st_q.cfg[0] == dsp_pkg::MODE_SRV_OUT && st_q.srv_en[0] |=> !pin_drv_out.o[0])
    else $error("servo output appeared on a measuring pin");

  frame_start_a: assert property ( // [RULE8]
    (srv4_on_s and st_q.frame == 20'h0) ##1 srv4_on_s
    |-> pin_drv_out.o[4] ##1 pin_drv_out.o[4])
    else $error("servo frame did not start high");

  pulse_end_a: assert property ( // [RULE10]
    srv4_on_s and st_q.frame == 20'(FRAME_CYC - 1) |=> !pin_drv_out.o[4])
    else $error("servo pulse still high at frame end");

  servo_off_a: assert property ( // [RULE10]
    !st_q.srv_en[5] && st_q.cfg[5] == dsp_pkg::MODE_SRV_OUT |=> !pin_drv_out.o[5])
    else $error("disabled servo output not low");

  measure_a: assert property ( // [RULE9]
    st_q.srv_en[0] && st_q.cfg[0] == dsp_pkg::MODE_SRV_IN && !st_q.s2[0] && st_q.s3[0]
    && 32'(st_q.meas[0]) >= PMAX_CYC |=> st_q.pos_in[0] == 8'hff)
    else $error("long pulse not reported as full position");

  cfg_write_a: assert property ( // [RULE2]
    bus_in.wr && bus_in.addr == dsp_pkg::ADDR_CFG
    |=> st_q.cfg == $past(bus_in.wdata[23:0]))
    else $error("configuration write not taken");

  unknown_code_a: assert property ( // [RULE2]
    st_q.cfg[6] == 3'h5
    |=> !pin_drv_out.oe[6] && pin_drv_out.pd[6])
    else $error("undefined code did not leave the pin an input");

  level_write_a: assert property ( // [RULE3]
    bus_in.wr && bus_in.addr == dsp_pkg::ADDR_STATE
    |=> st_q.level == $past(bus_in.wdata[7:0]))
    else $error("state write not taken");

  read_output_a: assert property ( // [RULE3]
    bus_in.rd && bus_in.addr == dsp_pkg::ADDR_STATE && st_q.cfg[2] == dsp_pkg::MODE_OUT
    |=> bus_rdata_out[2] == $past(pin_drv_out.o[2]))
    else $error("output read-back wrong");

  wrong_side_a: assert property ( // [RULE6]
    st_q.cfg[4] == dsp_pkg::MODE_SRV_IN
    |=> !pin_drv_out.oe[4] && pin_drv_out.pd[4])
    else $error("measure mode on a generating pin drove it");

  enable_only_a: assert property ( // [RULE7]
    st_q.srv_en[7] && st_q.cfg[7] == dsp_pkg::MODE_IN
    |=> !pin_drv_out.oe[7] && !pin_drv_out.o[7])
    else $error("servo enable acted without servo mode");

  measure_gate_a: assert property ( // [RULE7]
    st_q.srv_en[2] && st_q.cfg[2] != dsp_pkg::MODE_SRV_IN
    |=> $stable(st_q.pos_in[2]))
    else $error("position reported without measure mode");

  frame_period_a: assert property ( // [RULE8]
    st_q.frame == 20'(FRAME_CYC - 1)
    |=> st_q.frame == 20'h0)
    else $error("servo frame length wrong");

  pos_hold_a: assert property ( // [RULE8]
    st_q.frame != 20'h0
    |=> $stable(st_q.hold))
    else $error("position changed inside a frame");

  // bounds use the 1-2 ms limits, not pos2cyc, so a broken mapping still shows
  pulse_min_a: assert property ( // [RULE8]
    srv4_on_s and st_q.frame == 20'(PMIN_CYC - 1)
    |=> pin_drv_out.o[4])
    else $error("servo pulse shorter than the minimum");

  pulse_max_a: assert property ( // [RULE8]
    srv4_on_s and st_q.frame == 20'(PMAX_CYC)
    |=> !pin_drv_out.o[4])
    else $error("servo pulse longer than the maximum");

  pos_zero_a: assert property ( // [RULE10]
    srv4_on_s and (st_q.hold[0] == 8'h00 && st_q.frame == 20'(PMIN_CYC))
    |=> !pin_drv_out.o[4])
    else $error("lowest position not the shortest pulse");

  pos_full_a: assert property ( // [RULE10]
    srv5_on_s and (st_q.hold[1] == 8'hff && st_q.frame == 20'(PMAX_CYC - 1))
    |=> pin_drv_out.o[5])
    else $error("highest position not the longest pulse");

  measure_low_a: assert property ( // [RULE9]
    st_q.srv_en[0] && st_q.cfg[0] == dsp_pkg::MODE_SRV_IN && !st_q.s2[0] && st_q.s3[0]
    && 32'(st_q.meas[0]) <= PMIN_CYC |=> st_q.pos_in[0] == 8'h00)
    else $error("short pulse not reported as zero position");

  measure_off_a: assert property ( // [RULE9]
    !st_q.srv_en[1]
    |=> $stable(st_q.pos_in[1]))
    else $error("disabled measuring channel changed its position");

  frame_c: cover property (srv4_on_s and st_q.frame == 20'h0);
  measure_c: cover property (st_q.srv_en[0] && !st_q.s2[0] && st_q.s3[0]);
  readin_c: cover property (bus_in.rd && bus_in.addr == dsp_pkg::ADDR_POS_IN);
  pulse_c: cover property (srv5_on_s and st_q.hold[1] == 8'hff);
  plain_c: cover property (bus_in.wr && bus_in.addr == dsp_pkg::ADDR_STATE);
endmodule // dsp_top

// [verif/dsp_pin_model.sv]
// pin-level model of the far side: resolves driven, forced and pulled-down pins
`timescale 1ns/1ps
module dsp_pin_model (
  input  wire dsp_pkg::dsp_pin_drv_t drv_in,
  input  wire logic [7:0]            ext_en_in,
  input  wire logic [7:0]            ext_val_in,
  output logic [7:0]                 pin_out
);
  // a floating pin without pull-down reads high so a missing pull-down shows up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (drv_in.oe[i])
        pin_out[i] = drv_in.o[i];
      else if (ext_en_in[i])
        pin_out[i] = ext_val_in[i];
      else
        pin_out[i] = !drv_in.pd[i];
    end
  end
endmodule // dsp_pin_model

// [verif/dsp_top_tb.sv]
// self-checking bench for the eight-pin digital and servo port
`timescale 1ns/1ps
module dsp_top_tb;
  logic                  clk;
  logic                  rstn;
  dsp_pkg::dsp_bus_t     bus;
  logic [31:0]           rdata;
  logic [7:0]            pin;
  logic [7:0]            ext_en;
  logic [7:0]            ext_val;
  dsp_pkg::dsp_pin_drv_t drv;
  logic [31:0]           d;
  int                    err_total = 0;
  int                    checks = 0;
  int                    cyc = 0;

  // short frame keeps the run small: 200-cycle frame, 20 to 40 cycles high
  dsp_top #(.FRAME_CYC(200), .PMIN_CYC(20), .PMAX_CYC(40)) dut (
    .core_clk_in(clk), .resetn_in(rstn), .bus_in(bus),
    .bus_rdata_out(rdata), .pin_in(pin), .pin_drv_out(drv));
  dsp_pin_model peer (
    .drv_in(drv), .ext_en_in(ext_en), .ext_val_in(ext_val), .pin_out(pin));

  task automatic stop_test();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, s, e);
    end
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  function automatic logic [31:0] cfg_all(input logic [2:0] m);
    return {8'h00, {8{m}}};
  endfunction

  task automatic t_reset();
    chk({drv.o, drv.oe, drv.pd}, 32'h0000ff);
    rd(dsp_pkg::ADDR_CFG);
    chk(d, 32'h0);
    rd(8'h14);
    chk(d, 32'h0);
  endtask
  task automatic t_modes();
    logic [2:0] m[7] = '{dsp_pkg::MODE_IN, dsp_pkg::MODE_OUT, dsp_pkg::MODE_SRV_IN,
                         dsp_pkg::MODE_SRV_OUT, dsp_pkg::MODE_SIG_OUT, dsp_pkg::MODE_SIG_IN,
                         3'h5};
    logic [3:0] oe;
    foreach (m[i]) begin
      wr(dsp_pkg::ADDR_CFG, cfg_all(m[i]));
      rd(dsp_pkg::ADDR_CFG);
      chk(d, cfg_all(m[i]));
      oe = (m[i] == 3'h1 || m[i] == 3'h3 || m[i] == 3'h6) ? 4'hf : 4'h0;
      chk({drv.oe[7:4], drv.pd[7:4]}, {oe, ~oe});
    end
  endtask
  task automatic t_plain();
    wr(dsp_pkg::ADDR_CFG, cfg_all(dsp_pkg::MODE_OUT));
    wr(dsp_pkg::ADDR_STATE, 32'ha5);
    repeat (2) step();
    chk({drv.o, drv.oe}, 32'ha5ff);
    rd(dsp_pkg::ADDR_STATE);
    chk(d, 32'ha5);
    wr(dsp_pkg::ADDR_CFG, cfg_all(dsp_pkg::MODE_IN));
    ext_en <= 8'hff;
    ext_val <= 8'h3c;
    repeat (4) step();
    rd(dsp_pkg::ADDR_STATE);
    chk(d, 32'h3c);
    ext_en <= 8'h00;
    repeat (4) step();
    rd(dsp_pkg::ADDR_STATE);
    chk(d, 32'h0);
  endtask
  // syncs to a fresh frame, then counts high cycles over one frame
  task automatic meas(input int p, input int hi);
    int n;
    n = 0;
    for (int k = 0; k < 3; k++) begin
      for (int w = 0; w < 450 && drv.o[p] !== (k != 1); w++) step();
    end
    repeat (200) begin
      n += int'(drv.o[p] === 1'b1);
      step();
    end
    chk(n, hi);
    chk(drv.o[p], 1'b1);
  endtask
  task automatic t_srv_out();
    // pins 4-5 generate, pin 6 servo mode but disabled, pin 7 plain input although enabled, pin 0 on the wrong side
    wr(dsp_pkg::ADDR_CFG, 32'h000db003);
    wr(dsp_pkg::ADDR_POS_OUT, 32'h0000ff80);
    wr(dsp_pkg::ADDR_SRV_EN, 32'hb1);
    rd(dsp_pkg::ADDR_SRV_EN);
    chk(d, 32'hb1);
    rd(dsp_pkg::ADDR_POS_OUT);
    chk(d, 32'hff80);
    meas(4, 30);
    meas(5, 40);
    chk({drv.o[6], drv.oe[7]}, 2'b00);
    chk({drv.o[0], drv.oe[0]}, 2'b01);
    wr(dsp_pkg::ADDR_POS_OUT, 32'h0000ff00);
    meas(4, 20);
  endtask
  task automatic t_srv_in();
    int len[3] = '{10, 30, 45};
    logic [7:0] exp[3] = '{8'h00, 8'h7f, 8'hff};
    // pin 1 measure mode but disabled, pin 2 enabled but plain input
    wr(dsp_pkg::ADDR_CFG, 32'h12);
    wr(dsp_pkg::ADDR_SRV_EN, 32'h05);
    ext_en <= 8'h07;
    ext_val <= 8'h00;
    foreach (len[i]) begin
      @(posedge clk);
      ext_val <= 8'h07;
      repeat (len[i]) @(posedge clk);
      ext_val <= 8'h00;
      repeat (6) step();
      rd(dsp_pkg::ADDR_POS_IN);
      chk(d, {24'h0, exp[i]});
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    rstn = 1'b0;
    bus = '0;
    ext_en = 8'h00;
    ext_val = 8'h00;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) step();
    t_reset();
    t_modes();
    t_plain();
    t_srv_out();
    t_srv_in();
    stop_test();
  end
endmodule // dsp_top_tb
